// ---- standby_ctrl.sv ----
// Local design decisions: the register offsets and the APB slave port.
`timescale 1ns/1ps
// What this block does
// - system control register is eight bits, software readable and writable.
// - debugger soft reset bit 0 holds trace debug unit reset; 1 releases; resets 0.
// - ram enable 0 makes ram reads return undefined data and drops writes.
// - ram enable 1 gives normal ram access; the bit resets to 1.
// - both module stop registers are sixteen bits, readable and writable.
// - stop bit 1 puts its module in standby; 0 takes it out.
// - reserved bits read as documented ones or zeros; software writes same.
// - register one bit 11 stops ram, bit 10 rom, both reset 0.
// - register one bits 4..2 stop serial channels four..two, reset 1.
// - register two bits 14,13,12,9,5,4,0 stop timers, can, converters, break.
// - debug mode pin low keeps trace debug and debug interface running.
module standby_ctrl
(
   input  wire logic                      pclk,
   input  wire logic                      presetn,
   input  wire logic                      psel,
   input  wire logic                      penable,
   input  wire logic                      pwrite,
   input  wire logic [11:0]               paddr,
   input  wire logic [31:0]               pwdata,
   input  wire logic [3:0]                pstrb,
   output logic      [31:0]               prdata,
   output logic                           pready,
   output logic                           pslverr,
   input  wire logic                      debug_mode_pin,
   input  wire standby_ctrl_pkg::ram_req_t cpu_ram_req,
   output standby_ctrl_pkg::ram_req_t     mem_req,
   input  wire logic [31:0]               mem_rdata,
   output logic      [31:0]               cpu_rdata,
   output logic                           cpu_rvalid,
   output logic                           trace_debug_rst_n,
   output standby_ctrl_pkg::module_stop_t module_stop
);
   import standby_ctrl_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // helpers

   // read view: stored bits where writable, fixed ones, zeros elsewhere
   function automatic logic [15:0] reg_view(input logic [15:0] val,
                                            input logic [15:0] wmask,
                                            input logic [15:0] ones);
      reg_view = (val & wmask) | ones;
   endfunction

   // merge a write through byte strobes and the writable mask
   function automatic logic [15:0] reg_merge(input logic [15:0] old,
                                             input logic [15:0] wd,
                                             input logic [1:0]  strb,
                                             input logic [15:0] wmask);
      logic [15:0] m;
      m = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
      reg_merge = (old & ~m) | (wd & m);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // apb slave, one wait state

   logic [15:0] sys_ctrl_r;
   logic [15:0] stop_one_r;
   logic [15:0] stop_two_r;
   logic [15:0] sys_ctrl_nxt;
   logic [15:0] stop_one_nxt;
   logic [15:0] stop_two_nxt;
   logic [31:0] prdata_r;
   logic        pready_r;
   logic        pslverr_r;
   logic        access;
   logic        wr_commit;
   logic        hit_sys;
   logic        hit_one;
   logic        hit_two;
   logic [15:0] rd_val;
   logic        dbg_pin_q;

   assign access    = psel && penable;
   assign wr_commit = access && pready_r && pwrite;

   // address decode and read mux
   always_comb begin
      hit_sys = 1'b0;
      hit_one = 1'b0;
      hit_two = 1'b0;
      rd_val  = 16'h0000;
      if (paddr == SYS_CTRL_ADDR) begin
         hit_sys = 1'b1;
         rd_val  = reg_view(sys_ctrl_r, SYS_CTRL_WMASK, SYS_CTRL_ONES);
      end else if (paddr == STOP_ONE_ADDR) begin
         hit_one = 1'b1;
         rd_val  = reg_view(stop_one_r, STOP_ONE_WMASK, STOP_ONE_ONES);
      end else if (paddr == STOP_TWO_ADDR) begin
         hit_two = 1'b1;
         rd_val  = reg_view(stop_two_r, STOP_TWO_WMASK, STOP_TWO_ONES);
      end
   end

   // response registers; pready rises in the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h00000000;
         pslverr_r <= 1'b0;
      end else if (access && !pready_r) begin
         pready_r  <= 1'b1;
         prdata_r  <= pwrite ? 32'h00000000 : {16'h0000, rd_val};
         pslverr_r <= !(hit_sys || hit_one || hit_two);
      end else begin
         pready_r  <= 1'b0;
         prdata_r  <= 32'h00000000;
         pslverr_r <= 1'b0;
      end
   end

   assign prdata  = prdata_r;
   assign pready  = pready_r;
   assign pslverr = pslverr_r;

   ////////////////////////////////////////////////////////////////////////////
   // control registers

   // next values; a write lands on the edge that completes the transfer
   always_comb begin
      sys_ctrl_nxt = sys_ctrl_r;
      stop_one_nxt = stop_one_r;
      stop_two_nxt = stop_two_r;
      if (wr_commit && hit_sys) begin
         sys_ctrl_nxt = reg_merge(sys_ctrl_r, pwdata[15:0], pstrb[1:0], SYS_CTRL_WMASK);
      end
      if (wr_commit && hit_one) begin
         stop_one_nxt = reg_merge(stop_one_r, pwdata[15:0], pstrb[1:0], STOP_ONE_WMASK);
      end
      if (wr_commit && hit_two) begin
         stop_two_nxt = reg_merge(stop_two_r, pwdata[15:0], pstrb[1:0], STOP_TWO_WMASK);
      end
   end

   // stored register state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_ctrl_r <= SYS_CTRL_RST;
         stop_one_r <= STOP_ONE_RST;
         stop_two_r <= STOP_TWO_RST;
      end else begin
         sys_ctrl_r <= sys_ctrl_nxt;
         stop_one_r <= stop_one_nxt;
         stop_two_r <= stop_two_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // debug mode pin and module stop outputs

   pin_sync #(
      .RST_VAL (DBG_PIN_RST)
   ) u_dbg_sync (
      .pclk    (pclk),
      .presetn (presetn),
      .pin_in  (debug_mode_pin),
      .level_r (dbg_pin_q)
   );

   // stop lines follow the next register value, so they move on the write edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         module_stop       <= '0;
         trace_debug_rst_n <= 1'b0;
      end else begin
         trace_debug_rst_n              <= sys_ctrl_nxt[SOFT_RST_BIT];
         module_stop.ram_stop           <= stop_one_nxt[RAM_STOP_BIT];
         module_stop.rom_stop           <= stop_one_nxt[ROM_STOP_BIT];
         // both bits kept equal by software; the controller stops only on both
         module_stop.xfer_ctrl_stop     <= stop_one_nxt[XFER_HI_BIT]
                                           & stop_one_nxt[XFER_LO_BIT];
         module_stop.serial4_stop       <= stop_one_nxt[SER4_BIT];
         module_stop.serial3_stop       <= stop_one_nxt[SER3_BIT];
         module_stop.serial2_stop       <= stop_one_nxt[SER2_BIT];
         module_stop.motor_timer_stop   <= stop_two_nxt[MOTOR_BIT];
         module_stop.multi_timer_stop   <= stop_two_nxt[MULTI_BIT];
         module_stop.compare_timer_stop <= stop_two_nxt[CMP_BIT];
         module_stop.can_ctrl_stop      <= stop_two_nxt[CAN_BIT];
         module_stop.converter1_stop    <= stop_two_nxt[CONV1_BIT];
         module_stop.converter0_stop    <= stop_two_nxt[CONV0_BIT];
         module_stop.break_ctrl_stop    <= stop_two_nxt[BREAK_BIT];
         // in debug mode the debug units never stop
         module_stop.trace_debug_stop   <= stop_two_nxt[TRACE_BIT] & dbg_pin_q;
         module_stop.debug_iface_stop   <= stop_two_nxt[DIFACE_BIT] & dbg_pin_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // on-chip ram access gate

   logic ram_en;
   logic rd_pend_a_r;
   logic rd_pend_b_r;
   logic rd_en_a_r;
   logic rd_en_b_r;

   assign ram_en = sys_ctrl_r[RAM_EN_BIT];

   // forward requests only while enabled; writes are dropped otherwise
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_req <= '0;
      end else begin
         mem_req       <= cpu_ram_req;
         mem_req.valid <= cpu_ram_req.valid && ram_en;
      end
   end

   // read return, two edges after the request is taken
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rd_pend_a_r <= 1'b0;
         rd_pend_b_r <= 1'b0;
         rd_en_a_r   <= 1'b0;
         rd_en_b_r   <= 1'b0;
         cpu_rvalid  <= 1'b0;
         cpu_rdata   <= 32'h00000000;
      end else begin
         rd_pend_a_r <= cpu_ram_req.valid && !cpu_ram_req.write;
         rd_en_a_r   <= ram_en;
         rd_pend_b_r <= rd_pend_a_r;
         rd_en_b_r   <= rd_en_a_r;
         cpu_rvalid  <= rd_pend_b_r;
         cpu_rdata   <= rd_en_b_r ? mem_rdata : RAM_UNDEF_DATA;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions

   logic first_r;

   // high during reset and in the first cycle after reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_r <= 1'b1;
      end else begin
         first_r <= 1'b0;
      end
   end

   sequence s_rd_req;
      cpu_ram_req.valid && !cpu_ram_req.write;
   endsequence

   sequence s_sys_write(logic [1:0] val);
      wr_commit && hit_sys && pstrb[0] && (pwdata[1:0] == val);
   endsequence

   property p_sys_read;
      @(posedge pclk) disable iff (!presetn)
      access && !pready_r && !pwrite && hit_sys
      |=> pready_r && (prdata_r[31:2] == 30'h30) && !pslverr_r;
   endproperty
   a_sys_read: assert property (p_sys_read) else $error("system control read bad");

   property p_soft_reset;
      @(posedge pclk) disable iff (!presetn)
      s_sys_write(2'b01) |=> !trace_debug_rst_n ##1 !trace_debug_rst_n[*2];
   endproperty
   a_soft_reset: assert property (p_soft_reset) else $error("debugger not held in reset");

   property p_ram_off;
      @(posedge pclk) disable iff (!presetn)
      (s_rd_req ##0 !ram_en) |=> !mem_req.valid ##2 cpu_rvalid
                                 && (cpu_rdata == RAM_UNDEF_DATA);
   endproperty
   a_ram_off: assert property (p_ram_off) else $error("disabled ram returned data");

   property p_ram_on;
      @(posedge pclk) disable iff (!presetn)
      (s_rd_req ##0 ram_en) |=> mem_req.valid ##2 cpu_rvalid
                                && (cpu_rdata == $past(mem_rdata));
   endproperty
   a_ram_on: assert property (p_ram_on) else $error("enabled ram access lost");

   property p_wide_read;
      @(posedge pclk) disable iff (!presetn)
      pready_r |-> (prdata_r[31:16] == 16'h0000);
   endproperty
   a_wide_read: assert property (p_wide_read) else $error("upper read bits set");

   property p_can_stop;
      @(posedge pclk) disable iff (!presetn)
      wr_commit && hit_two && pstrb[1] |=> module_stop.can_ctrl_stop == $past(pwdata[CAN_BIT]);
   endproperty
   a_can_stop: assert property (p_can_stop) else $error("can stop not updated");

   property p_fixed_bits;
      @(posedge pclk) disable iff (!presetn)
      pready_r && !pslverr_r && !pwrite && $past(hit_two)
      |-> (prdata_r[15:0] & ~STOP_TWO_WMASK) == STOP_TWO_ONES;
   endproperty
   a_fixed_bits: assert property (p_fixed_bits) else $error("reserved bits wrong");

   property p_reset_vals;
      @(posedge pclk) disable iff (!presetn)
      $fell(first_r) |-> !module_stop.ram_stop && !module_stop.rom_stop
                  && module_stop.serial4_stop && module_stop.serial2_stop;
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("stop reset values wrong");

   property p_debug_run;
      @(posedge pclk) disable iff (!presetn)
      !dbg_pin_q |=> !module_stop.trace_debug_stop && !module_stop.debug_iface_stop;
   endproperty
   a_debug_run: assert property (p_debug_run) else $error("debug unit stopped");

   property p_stop_timing;
      @(posedge pclk) disable iff (!presetn)
      wr_commit && hit_two && pstrb[1]
      |=> module_stop.motor_timer_stop == $past(pwdata[MOTOR_BIT]); 
   endproperty
   a_stop_timing: assert property (p_stop_timing) else $error("motor stop late");

endmodule

// ---- standby_ctrl_pkg.sv ----
package standby_ctrl_pkg;

   // register byte addresses
   localparam logic [11:0] SYS_CTRL_ADDR  = 12'h000;
   localparam logic [11:0] STOP_ONE_ADDR  = 12'h004;
   localparam logic [11:0] STOP_TWO_ADDR  = 12'h008;

   // system control: writable bits, fixed ones, reset value
   localparam logic [15:0] SYS_CTRL_WMASK = 16'h0003;
   localparam logic [15:0] SYS_CTRL_ONES  = 16'h00C0;
   localparam logic [15:0] SYS_CTRL_RST   = 16'h00C1;
   localparam int          SOFT_RST_BIT   = 1;
   localparam int          RAM_EN_BIT     = 0;

   // module stop one
   localparam logic [15:0] STOP_ONE_WMASK = 16'h0F1C;
   localparam logic [15:0] STOP_ONE_ONES  = 16'hF023;
   localparam logic [15:0] STOP_ONE_RST   = 16'hF03F;
   localparam int          RAM_STOP_BIT   = 11;
   localparam int          ROM_STOP_BIT   = 10;
   localparam int          XFER_HI_BIT    = 9;
   localparam int          XFER_LO_BIT    = 8;
   localparam int          SER4_BIT       = 4;
   localparam int          SER3_BIT       = 3;
   localparam int          SER2_BIT       = 2;

   // module stop two
   localparam logic [15:0] STOP_TWO_WMASK = 16'h723D;
   localparam logic [15:0] STOP_TWO_ONES  = 16'h80C0;
   localparam logic [15:0] STOP_TWO_RST   = 16'hF0F0;
   localparam int          MOTOR_BIT      = 14;
   localparam int          MULTI_BIT      = 13;
   localparam int          CMP_BIT        = 12;
   localparam int          CAN_BIT        = 9;
   localparam int          CONV1_BIT      = 5;
   localparam int          CONV0_BIT      = 4;
   localparam int          TRACE_BIT      = 3;
   localparam int          DIFACE_BIT     = 2;
   localparam int          BREAK_BIT      = 0;

   // value returned for reads of disabled ram (arbitrary)
   localparam logic [31:0] RAM_UNDEF_DATA = 32'hFFFFFFFF;
   // level of the debug mode pin at reset: normal mode
   localparam logic        DBG_PIN_RST    = 1'b1;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
      logic [31:0] wdata;
   } ram_req_t;

   typedef struct packed {
      logic ram_stop;
      logic rom_stop;
      logic xfer_ctrl_stop;
      logic serial4_stop;
      logic serial3_stop;
      logic serial2_stop;
      logic motor_timer_stop;
      logic multi_timer_stop;
      logic compare_timer_stop;
      logic can_ctrl_stop;
      logic converter1_stop;
      logic converter0_stop;
      logic trace_debug_stop;
      logic debug_iface_stop;
      logic break_ctrl_stop;
   } module_stop_t;

endpackage

// ---- pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
   parameter logic RST_VAL = 1'b1
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pin_in,
   output logic      level_r
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   // three stages; a change counts once the last two agree
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r    <= RST_VAL;
         s2_r    <= RST_VAL;
         s3_r    <= RST_VAL;
         level_r <= RST_VAL;
      end else begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            level_r <= s3_r;
         end
      end
   end
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
   import standby_ctrl_pkg::*;

   logic         pclk;
   logic         presetn;
   logic         psel;
   logic         penable;
   logic         pwrite;
   logic [11:0]  paddr;
   logic [31:0]  pwdata;
   logic [3:0]   pstrb;
   logic [31:0]  prdata;
   logic         pready;
   logic         pslverr;
   logic         debug_mode_pin;
   ram_req_t     cpu_ram_req;
   ram_req_t     mem_req;
   logic [31:0]  mem_rdata;
   logic [31:0]  cpu_rdata;
   logic         cpu_rvalid;
   logic         trace_debug_rst_n;
   module_stop_t module_stop;
   int           miscompares;
   int           comparisons;
   int           cycles;
   int           seed;
   logic [31:0]  rd;
   logic         er;
   logic [31:0]  r;
   logic [15:0]  mir [3];
   logic [15:0]  wm  [3];
   logic [15:0]  on  [3];
   logic [11:0]  adr [3];

   standby_ctrl standby_ctrl_i (
      .pclk              (pclk),
      .presetn           (presetn),
      .psel              (psel),
      .penable           (penable),
      .pwrite            (pwrite),
      .paddr             (paddr),
      .pwdata            (pwdata),
      .pstrb             (pstrb),
      .prdata            (prdata),
      .pready            (pready),
      .pslverr           (pslverr),
      .debug_mode_pin    (debug_mode_pin),
      .cpu_ram_req       (cpu_ram_req),
      .mem_req           (mem_req),
      .mem_rdata         (mem_rdata),
      .cpu_rdata         (cpu_rdata),
      .cpu_rvalid        (cpu_rvalid),
      .trace_debug_rst_n (trace_debug_rst_n),
      .module_stop       (module_stop)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // 200 MHz clock and hang guard
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares = miscompares + 1;
         final_report();
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // compare, verdict and expected stop levels
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp) begin
         miscompares = miscompares + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   function automatic module_stop_t exp_stop(input logic [15:0] a, input logic [15:0] b,
                                             input logic dbg);
      module_stop_t s;
      s.ram_stop           = a[RAM_STOP_BIT];
      s.rom_stop           = a[ROM_STOP_BIT];
      s.xfer_ctrl_stop     = a[XFER_HI_BIT] & a[XFER_LO_BIT];
      s.serial4_stop       = a[SER4_BIT];
      s.serial3_stop       = a[SER3_BIT];
      s.serial2_stop       = a[SER2_BIT];
      s.motor_timer_stop   = b[MOTOR_BIT];
      s.multi_timer_stop   = b[MULTI_BIT];
      s.compare_timer_stop = b[CMP_BIT];
      s.can_ctrl_stop      = b[CAN_BIT];
      s.converter1_stop    = b[CONV1_BIT];
      s.converter0_stop    = b[CONV0_BIT];
      s.trace_debug_stop   = b[TRACE_BIT] & dbg;
      s.debug_iface_stop   = b[DIFACE_BIT] & dbg;
      s.break_ctrl_stop    = b[BREAK_BIT];
      return s;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // apb transfer: setup, access, hold until pready
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // write a register through lanes s, read it back, check stop outputs
   task automatic put(input int k, input logic [15:0] wd, input logic [3:0] s);
      logic [15:0] lm;
      lm = {{8{s[1]}}, {8{s[0]}}};
      if (k == 1)
         wd[XFER_LO_BIT] = wd[XFER_HI_BIT];
      mir[k] = (mir[k] & ~(wm[k] & lm)) | (wd & wm[k] & lm) | on[k];
      apb(1'b1, adr[k], {16'h0000, wd}, s, rd, er);
      chk(er, 0);
      apb(1'b0, adr[k], 32'h00000000, 4'h0, rd, er);
      chk(rd, {16'h0000, mir[k]});
      repeat (2) @(posedge pclk);
      #1;
      chk(module_stop, exp_stop(mir[1], mir[2], debug_mode_pin));
      chk(trace_debug_rst_n, mir[0][SOFT_RST_BIT]);
   endtask

   // one cpu ram access; en is the expected ram enable
   task automatic ram_op(input logic wr, input logic en);
      ram_req_t    q;
      logic [31:0] d;
      q.valid = 1'b1;
      q.write = wr;
      q.addr = 16'($random(seed));
      q.wdata = $random(seed);
      d = $random(seed);
      @(posedge pclk);
      cpu_ram_req <= q;
      @(posedge pclk);
      cpu_ram_req <= '0;
      #1;
      chk(mem_req.valid, en);
      if (en)
         chk(mem_req, q);
      @(posedge pclk);
      mem_rdata <= d;
      @(posedge pclk);
      mem_rdata <= ~d;
      #1;
      if (!wr) begin
         chk(cpu_rvalid, 1);
         chk(cpu_rdata, en ? d : RAM_UNDEF_DATA);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      seed = 32'h11a7;
      miscompares = 0;
      comparisons = 0;
      cycles = 0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = '0;
      debug_mode_pin = 1'b1;
      cpu_ram_req = '0;
      mem_rdata = '0;
      mir = '{SYS_CTRL_RST, STOP_ONE_RST, STOP_TWO_RST};
      wm = '{SYS_CTRL_WMASK, STOP_ONE_WMASK, STOP_TWO_WMASK};
      on = '{SYS_CTRL_ONES, STOP_ONE_ONES, STOP_TWO_ONES};
      adr = '{SYS_CTRL_ADDR, STOP_ONE_ADDR, STOP_TWO_ADDR};
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      #1;
      chk(module_stop, exp_stop(16'hF03F, 16'hF0F0, 1'b1));
      chk(trace_debug_rst_n, 0);
      // reset values read back
      for (int k = 0; k < 3; k++) begin
         apb(1'b0, adr[k], 32'h00000000, 4'h0, rd, er);
         chk(rd, {16'h0000, mir[k]});
      end
      // unmapped places refuse
      apb(1'b0, 12'h00C, 32'h00000000, 4'h0, rd, er);
      chk({er, rd}, {1'b1, 32'h00000000});
      apb(1'b1, 12'h104, 32'hFFFFFFFF, 4'hF, rd, er);
      chk(er, 1);
      // full ones, full zeros, then random writes and lanes
      for (int i = 0; i < 24; i++) begin
         r = (i == 0) ? 32'hFFFFFFFF : (i == 1) ? 32'h00000000 : $random(seed);
         if (i < 6)
            put(i % 3, r[15:0] & wm[i % 3] | on[i % 3], 4'hF);
         else
            put(int'(r[21:20]) % 3, r[15:0] & wm[int'(r[21:20]) % 3]
                | on[int'(r[21:20]) % 3], {r[19:18], i[0] ? r[17:16] : 2'b11});
      end
      // ram gate on, off, on again
      put(0, 16'h00C3, 4'h1);
      ram_op(1'b0, 1'b1);
      ram_op(1'b1, 1'b1);
      put(0, 16'h00C2, 4'h1);
      ram_op(1'b0, 1'b0);
      ram_op(1'b1, 1'b0);
      put(0, 16'h00C1, 4'h1);
      ram_op(1'b0, 1'b1);
      // debug mode keeps trace and debug interface running
      put(2, STOP_TWO_ONES | 16'h000C, 4'h3);
      @(posedge pclk);
      debug_mode_pin <= 1'b0;
      repeat (6) @(posedge pclk);
      #1;
      chk(module_stop, exp_stop(mir[1], mir[2], 1'b0));
      put(2, STOP_TWO_ONES | 16'h700C, 4'h3);
      @(posedge pclk);
      debug_mode_pin <= 1'b1;
      repeat (6) @(posedge pclk);
      #1;
      chk(module_stop, exp_stop(mir[1], mir[2], 1'b1));
      // ram enable cleared ahead of standby, then a mid-run reset restores defaults
      put(0, 16'h00C2, 4'h1);
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      mir = '{SYS_CTRL_RST, STOP_ONE_RST, STOP_TWO_RST};
      repeat (2) @(posedge pclk);
      #1;
      chk(module_stop, exp_stop(STOP_ONE_RST, STOP_TWO_RST, 1'b1));
      chk(trace_debug_rst_n, 0);
      apb(1'b0, adr[0], 32'h00000000, 4'h0, rd, er);
      chk(rd, {16'h0000, mir[0]});
      final_report();
   end
endmodule
